// ### rtl/clock_gen_map.svh
// Offsets, field positions, reset values and limits of the clock generator pin control.
`ifndef CLOCK_GEN_MAP_SVH
`define CLOCK_GEN_MAP_SVH
`define REG_CTRL 8'h00
`define REG_OE 8'h04
`define REG_SS0 8'h08
`define REG_SS1 8'h0C
`define REG_INTDIV_BASE 8'h10
`define REG_STATUS 8'h30
`define REG_PINCFG_BASE 8'h40
`define CTRL_SSEN_LSB 0
`define CTRL_CENTER_LSB 2
`define CTRL_MSFS_LSB 4
`define CTRL_INTFS_LSB 6
`define CTRL_ADDR_BIT 11
`define CTRL_CLKSEL_LSB 12
`define SS_MAG_MIN 5'h01
`define SS_MAG_MAX 5'h19
`define SS_FREQ_LSB 8
`define SS_FREQ_MAX_MHZ 10'h0FA
`define INTDIV_MIN 8'h08
`define INTDIV_MAX 8'hFF
`define INTDIV_RESET 16'h0808
`define PINCFG_IDX_LSB 4
`define PINCFG_MASK_LSB 8
`define BUS_ADDR_BASE 7'h6A
`define GATE_DRAIN_FALLS 2'h1
`endif

// ### rtl/clock_gen_pin_control.sv
// Pin and register control of a multi-output clock generator.
//
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "clock_gen_map.svh"
module clock_gen_pin_control
  import clock_gen_pkg::*;
#(
  parameter int NUM_PINS = 8,
  parameter int NUM_OUT = 6,
  parameter int NUM_INT = 5,
  parameter int NUM_MS = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire reg_req_s regReq,
  output logic [31:0] regRdata,
  input wire logic [NUM_PINS-1:0] hwPins,
  input wire logic [NUM_OUT-1:0] outClkLevel,
  output logic [NUM_OUT-1:0] diffOutTrue,
  output logic [NUM_OUT-1:0] diffOutComplement,
  output logic [NUM_OUT-1:0] driverEnable,
  output spread_cfg_s [NUM_MS-1:0] spreadCfg,
  output logic [NUM_INT-1:0][7:0] intDivValue,
  output logic [6:0] busAddress,
  output logic [1:0] inputSourceSelect,
  output logic [NUM_PINS-1:0] profileSelect
);

  // ---------------------------------------------------------------
  // Volatile registers
  // ---------------------------------------------------------------
  // Writes reach only these flops and are never copied to stored profiles,
  // so they vanish with power. Pin assignments stand for stored configuration
  // and survive a reset, so that profile pins can be sampled when it ends.
  // Until a pin is assigned it carries no function.
  logic [13:0] ctrl_r;
  logic [NUM_OUT-1:0] oeReg_r;
  logic [NUM_MS-1:0][17:0] ssReg_r;
  logic [NUM_INT-1:0][15:0] intDiv_r;
  logic [NUM_PINS-1:0][15:0] pinCfg_r;

  function automatic logic pinMatch(input logic [15:0] cfg, input pin_func_e fn,
                                    input int idx);
    pinMatch = (cfg[3:0] == fn) && (int'(cfg[7:`PINCFG_IDX_LSB]) == idx);
  endfunction : pinMatch

  function automatic logic [7:0] clampDiv(input logic [7:0] v);
    clampDiv = (v < `INTDIV_MIN) ? `INTDIV_MIN : v;
  endfunction : clampDiv

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_r <= '0;
      oeReg_r <= '1;
      ssReg_r <= '0;
      intDiv_r <= {NUM_INT{`INTDIV_RESET}};
    end else if (regReq.wr) begin
      if (regReq.addr == `REG_CTRL) begin
        ctrl_r <= regReq.wdata[13:0];
      end else if (regReq.addr == `REG_OE) begin
        oeReg_r <= regReq.wdata[NUM_OUT-1:0];
      end else if (regReq.addr == `REG_SS0) begin
        ssReg_r[0] <= regReq.wdata[17:0];
      end else if (regReq.addr == `REG_SS1) begin
        ssReg_r[1] <= regReq.wdata[17:0];
      end
      for (int i = 0; i < NUM_INT; i++) begin
        if (regReq.addr == `REG_INTDIV_BASE + 8'(4 * i)) begin
          intDiv_r[i] <= regReq.wdata[15:0];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (regReq.wr) begin
      for (int i = 0; i < NUM_PINS; i++) begin
        if (regReq.addr == `REG_PINCFG_BASE + 8'(4 * i)) begin
          pinCfg_r[i] <= regReq.wdata[15:0];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Pin override resolution
  // ---------------------------------------------------------------
  // A pin assigned to a function masks the matching register bit; when
  // several pins claim one function the highest numbered pin wins.
  logic [NUM_MS-1:0] ssEnEff;
  logic [NUM_MS-1:0] msFsEff;
  logic [NUM_INT-1:0] intFsEff;
  logic [NUM_OUT-1:0] oeEff;
  logic addrLsbEff;
  logic [1:0] clkSelEff;
  logic [NUM_PINS-1:0] profileEff;

  always_comb begin
    ssEnEff = ctrl_r[`CTRL_SSEN_LSB +: NUM_MS];
    msFsEff = ctrl_r[`CTRL_MSFS_LSB +: NUM_MS];
    intFsEff = ctrl_r[`CTRL_INTFS_LSB +: NUM_INT];
    oeEff = oeReg_r;
    addrLsbEff = ctrl_r[`CTRL_ADDR_BIT];
    clkSelEff = ctrl_r[`CTRL_CLKSEL_LSB +: 2];
    profileEff = '0;
    for (int p = 0; p < NUM_PINS; p++) begin
      for (int m = 0; m < NUM_MS; m++) begin
        if (pinMatch(pinCfg_r[p], FN_SSEN, m)) begin
          ssEnEff[m] = hwPins[p];
        end
        if (pinMatch(pinCfg_r[p], FN_FS_MS, m)) begin
          msFsEff[m] = hwPins[p];
        end
      end
      for (int d = 0; d < NUM_INT; d++) begin
        if (pinMatch(pinCfg_r[p], FN_FS_INT, d)) begin
          intFsEff[d] = hwPins[p];
        end
      end
      if (pinCfg_r[p][3:0] == FN_OE) begin
        // The mask names any set of outputs, one bit for each output.
        for (int o = 0; o < NUM_OUT; o++) begin
          if (pinCfg_r[p][`PINCFG_MASK_LSB + o]) begin
            oeEff[o] = ~hwPins[p];
          end
        end
      end
      if (pinCfg_r[p][3:0] == FN_ADDR) begin
        addrLsbEff = hwPins[p];
      end
      for (int b = 0; b < 2; b++) begin
        if (pinMatch(pinCfg_r[p], FN_CLKSEL, b)) begin
          clkSelEff[b] = hwPins[p];
        end
      end
      if (pinCfg_r[p][3:0] == FN_PROFILE) begin
        profileEff[p] = hwPins[p];
      end
    end
  end

  // ---------------------------------------------------------------
  // Spread, divider, address and source outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      spreadCfg <= '0;
      intDivValue <= {NUM_INT{`INTDIV_MIN}};
      busAddress <= `BUS_ADDR_BASE;
      inputSourceSelect <= '0;
    end else begin
      for (int m = 0; m < NUM_MS; m++) begin
        // Each synthesizer is handled alone, so both profiles run at once.
        spreadCfg[m].active <= ssEnEff[m] &&
          (ssReg_r[m][`SS_FREQ_LSB +: 10] <= `SS_FREQ_MAX_MHZ);
        spreadCfg[m].center <= ctrl_r[`CTRL_CENTER_LSB + m];
        if (ssReg_r[m][4:0] < `SS_MAG_MIN) begin
          spreadCfg[m].magnitude <= `SS_MAG_MIN;
        end else if (ssReg_r[m][4:0] > `SS_MAG_MAX) begin
          spreadCfg[m].magnitude <= `SS_MAG_MAX;
        end else begin
          spreadCfg[m].magnitude <= ssReg_r[m][4:0];
        end
        spreadCfg[m].profileSel <= msFsEff[m];
      end
      for (int d = 0; d < NUM_INT; d++) begin
        intDivValue[d] <= intFsEff[d] ? clampDiv(intDiv_r[d][15:8])
                                      : clampDiv(intDiv_r[d][7:0]);
      end
      busAddress <= {6'(`BUS_ADDR_BASE >> 1), addrLsbEff};
      // Switching here may glitch downstream; the source is not retimed.
      inputSourceSelect <= clkSelEff;
    end
  end

  // ---------------------------------------------------------------
  // Power-up profile capture
  // ---------------------------------------------------------------
  // Profile pins are taken once, in the first cycle after reset release.
  logic profileTaken_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      profileTaken_r <= 1'b0;
      profileSelect <= '0;
    end else if (!profileTaken_r) begin
      profileTaken_r <= 1'b1;
      profileSelect <= profileEff;
    end
  end

  // ---------------------------------------------------------------
  // Synchronous output gating
  // ---------------------------------------------------------------
  // Gating changes only at a falling edge of the output clock, so a high
  // phase is never cut short. Disable waits two falls, so the driver drops
  // one to two output periods after the request. Enable takes one fall.
  gate_state_e gateState_r [NUM_OUT];
  logic [1:0] fallCnt_r [NUM_OUT];
  logic [NUM_OUT-1:0] levelPrev_r;

  generate
    for (genvar o = 0; o < NUM_OUT; o++) begin : g_gate
      logic fall;
      assign fall = levelPrev_r[o] & ~outClkLevel[o];

      always_ff @(posedge clk) begin
        if (rst) begin
          levelPrev_r[o] <= 1'b0;
        end else begin
          levelPrev_r[o] <= outClkLevel[o];
        end
      end

      always_ff @(posedge clk) begin
        if (rst) begin
          gateState_r[o] <= GATE_OFF;
          fallCnt_r[o] <= '0;
        end else begin
          case (gateState_r[o])
            GATE_OFF: begin
              if (oeEff[o] && fall) begin
                gateState_r[o] <= GATE_ON;
              end
            end
            GATE_ON: begin
              if (!oeEff[o]) begin
                gateState_r[o] <= GATE_DRAIN;
                fallCnt_r[o] <= '0;
              end
            end
            GATE_DRAIN: begin
              if (oeEff[o]) begin
                gateState_r[o] <= GATE_ON;
              end else if (fall) begin
                if (fallCnt_r[o] == `GATE_DRAIN_FALLS) begin
                  gateState_r[o] <= GATE_OFF;
                end
                fallCnt_r[o] <= fallCnt_r[o] + 2'h1;
              end
            end
            default: begin
              gateState_r[o] <= GATE_OFF;
            end
          endcase
        end
      end

      always_ff @(posedge clk) begin
        if (rst) begin
          diffOutTrue[o] <= 1'b0;
          diffOutComplement[o] <= 1'b0;
          driverEnable[o] <= 1'b0;
        end else begin
          // Both halves of one buffer share the gate; disabled means low.
          driverEnable[o] <= (gateState_r[o] != GATE_OFF);
          diffOutTrue[o] <= (gateState_r[o] != GATE_OFF) & outClkLevel[o];
          diffOutComplement[o] <= (gateState_r[o] != GATE_OFF) & ~outClkLevel[o];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  logic [31:0] rdNxt;

  always_comb begin
    rdNxt = '0;
    if (regReq.addr == `REG_CTRL) begin
      rdNxt[13:0] = ctrl_r;
    end else if (regReq.addr == `REG_OE) begin
      rdNxt[NUM_OUT-1:0] = oeReg_r;
    end else if (regReq.addr == `REG_SS0) begin
      rdNxt[17:0] = ssReg_r[0];
    end else if (regReq.addr == `REG_SS1) begin
      rdNxt[17:0] = ssReg_r[1];
    end else if (regReq.addr == `REG_STATUS) begin
      rdNxt[NUM_MS-1:0] = ssEnEff;
      rdNxt[4 +: NUM_MS] = msFsEff;
      rdNxt[8 +: NUM_INT] = intFsEff;
      rdNxt[16 +: NUM_OUT] = driverEnable;
      rdNxt[28] = addrLsbEff;
      rdNxt[30:29] = clkSelEff;
    end
    for (int i = 0; i < NUM_INT; i++) begin
      if (regReq.addr == `REG_INTDIV_BASE + 8'(4 * i)) begin
        rdNxt[15:0] = intDiv_r[i];
      end
    end
    for (int i = 0; i < NUM_PINS; i++) begin
      if (regReq.addr == `REG_PINCFG_BASE + 8'(4 * i)) begin
        rdNxt[15:0] = pinCfg_r[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      regRdata <= '0;
    end else if (regReq.rd) begin
      regRdata <= rdNxt;
    end else begin
      regRdata <= '0;
    end
  end

endmodule : clock_gen_pin_control
`default_nettype wire

// ### rtl/clock_gen_pkg.sv
// Types shared by the clock generator pin control.
package clock_gen_pkg;
  typedef enum logic [3:0] {
    FN_NONE, FN_SSEN, FN_FS_INT, FN_FS_MS, FN_OE, FN_ADDR, FN_CLKSEL, FN_PROFILE
  } pin_func_e;
  typedef enum logic [1:0] {GATE_OFF, GATE_ON, GATE_DRAIN} gate_state_e;
  typedef struct packed {
    logic active;
    logic center;
    logic [4:0] magnitude;
    logic profileSel;
  } spread_cfg_s;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;
endpackage : clock_gen_pkg

// ### tb/clock_gen_pin_control_asserts.sv
// Port-level assertions for the clock generator pin control.
`timescale 1ns/1ps
`default_nettype none
module clock_gen_pin_control_asserts
  import clock_gen_pkg::*;
#(
  parameter int NUM_PINS = 8,
  parameter int NUM_OUT = 6,
  parameter int NUM_INT = 5,
  parameter int NUM_MS = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire reg_req_s regReq,
  input wire logic [31:0] regRdata,
  input wire logic [NUM_OUT-1:0] outClkLevel,
  input wire logic [NUM_OUT-1:0] diffOutTrue,
  input wire logic [NUM_OUT-1:0] diffOutComplement,
  input wire logic [NUM_OUT-1:0] driverEnable,
  input wire spread_cfg_s [NUM_MS-1:0] spreadCfg,
  input wire logic [NUM_INT-1:0][7:0] intDivValue,
  input wire logic [6:0] busAddress,
  input wire logic [NUM_PINS-1:0] profileSelect
);
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Gate changes must sit close behind a fall of the output clock, never mid-period.
  logic prevLvl_r;
  logic [3:0] sinceFall_r;
  always_ff @(posedge clk) begin
    prevLvl_r <= outClkLevel[0];
  end
  always_ff @(posedge clk) begin
    if (rst || (prevLvl_r && !outClkLevel[0])) sinceFall_r <= 4'h0;
    else if (sinceFall_r != 4'hF) sinceFall_r <= sinceFall_r + 4'h1;
  end
  sequence held_on_s;
    driverEnable[0] ##1 driverEnable[0];
  endsequence
  idle_read_zero_a: assert property (!regReq.rd |=> regRdata == 32'h0)
    else $error("read data outside read slot");
  pair_apart_a: assert property (held_on_s |-> diffOutTrue[0] != diffOutComplement[0])
    else $error("true and complement not paired");
  off_quiet_a: assert property ($fell(driverEnable[0]) |-> !diffOutTrue[0] && !diffOutComplement[0])
    else $error("output not quiet when disabled");
  stop_after_fall_a: assert property ($fell(driverEnable[0]) |-> sinceFall_r <= 4'h3)
    else $error("driver stopped mid period");
  start_after_fall_a: assert property ($rose(driverEnable[0]) |-> sinceFall_r <= 4'h3)
    else $error("driver started mid period");
  addr_base_a: assert property (busAddress[6:1] == 6'h35)
    else $error("bus address upper bits wrong");
  profile_hold_a: assert property (!$past(rst) && !$past(rst, 2) |-> $stable(profileSelect))
    else $error("profile select moved after start");
  for (genvar i = 0; i < NUM_INT; i++) begin : g_div
    div_floor_a: assert property (intDivValue[i] >= 8'h08)
      else $error("divide value below eight");
  end
  for (genvar m = 0; m < NUM_MS; m++) begin : g_ss
    spread_range_a: assert property (spreadCfg[m].active |-> spreadCfg[m].magnitude inside {[5'h01:5'h19]})
      else $error("spread magnitude out of range");
  end
endmodule : clock_gen_pin_control_asserts
`default_nettype wire

// ### tb/out_clock_source.sv
// Model of the output clocks whose falls pace the driver gating.
`timescale 1ns/1ps
`default_nettype none
module out_clock_source #(
  parameter int HALF = 2
) (
  input wire logic clk,
  input wire logic rst,
  output logic [5:0] outClk
);
  // ----------------------------------------
  // Divider
  // ----------------------------------------
  logic [7:0] cnt_r;
  always_ff @(posedge clk) begin
    if (rst || cnt_r == 8'(HALF - 1)) cnt_r <= 8'h00;
    else cnt_r <= cnt_r + 8'h01;
  end
  always_ff @(posedge clk) begin
    if (rst) outClk <= 6'h00;
    else if (cnt_r == 8'(HALF - 1)) outClk <= ~outClk;
  end
endmodule : out_clock_source
`default_nettype wire

// ### tb/tb.sv
// Self-checking bench for the clock generator pin control.
`timescale 1ns/1ps
`default_nettype none
`include "clock_gen_map.svh"
module tb
  import clock_gen_pkg::*;
;
  // ----------------------------------------
  // Bench
  // ----------------------------------------
  logic clk = 1'b0;
  logic rst;
  reg_req_s regReq;
  logic [31:0] regRdata;
  logic [7:0] hwPins;
  logic [5:0] outClkLevel;
  logic [5:0] diffOutTrue;
  logic [5:0] diffOutComplement;
  logic [5:0] driverEnable;
  spread_cfg_s [1:0] spreadCfg;
  logic [4:0][7:0] intDivValue;
  logic [6:0] busAddress;
  logic [1:0] inputSourceSelect;
  logic [7:0] profileSelect;
  logic [31:0] seed = 32'h43;
  logic [31:0] a;
  logic [31:0] b;
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;
  always #2.5 clk = ~clk;
  clock_gen_pin_control u_dut (.clk(clk), .rst(rst), .regReq(regReq), .regRdata(regRdata),
    .hwPins(hwPins), .outClkLevel(outClkLevel), .diffOutTrue(diffOutTrue),
    .diffOutComplement(diffOutComplement), .driverEnable(driverEnable), .spreadCfg(spreadCfg),
    .intDivValue(intDivValue), .busAddress(busAddress), .inputSourceSelect(inputSourceSelect),
    .profileSelect(profileSelect));
  out_clock_source u_src (.clk(clk), .rst(rst), .outClk(outClkLevel));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  task automatic complete_run();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask : settle
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    regReq <= '{addr: ad, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    regReq.wr <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [7:0] ad, input logic [31:0] e);
    @(posedge clk);
    regReq <= '{addr: ad, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    regReq.rd <= 1'b0;
    #1 chk(regRdata, e);
  endtask : rdc
  task automatic pin(input int idx, input logic v);
    @(posedge clk);
    hwPins[idx] <= v;
    settle();
  endtask : pin
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      miscompares++;
      complete_run();
    end
  end
  initial begin
    rst = 1'b1;
    regReq = '0;
    hwPins = 8'h00;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rdc(`REG_CTRL, 32'h0);
    rdc(`REG_OE, 32'h3F);
    rdc(`REG_INTDIV_BASE, 32'h0808);
    rdc(8'hF0, 32'h0);
    repeat (10) @(posedge clk);
    #1 chk(32'(driverEnable), 32'h3F);
    chk(32'(busAddress), 32'h6A);
    chk(32'(profileSelect), 32'h0);
    $display("test reset done");
    a = 32'h1 + xs() % 32'd25;
    b = xs() % 32'd251;
    wr(`REG_SS0, (b << 8) | a);
    wr(`REG_SS1, 32'h6405);
    wr(`REG_CTRL, 32'h7);
    settle();
    chk(32'(spreadCfg[0]), {24'h0, 2'b11, a[4:0], 1'b0});
    chk(32'(spreadCfg[1]), {24'h0, 2'b10, 5'h05, 1'b0});
    wr(`REG_SS0, 32'hFB05);
    settle();
    chk(32'(spreadCfg[0].active), 32'h0);
    wr(`REG_SS0, 32'h6405);
    wr(`REG_PINCFG_BASE, 32'h1);
    for (int v = 0; v < 2; v++) begin
      pin(0, v[0]);
      chk(32'(spreadCfg[0].active), v);
    end
    wr(8'h58, 32'h13);
    pin(6, 1'b1);
    chk(32'(spreadCfg[1].profileSel), 32'h1);
    $display("test spread done");
    a = 32'h8 + xs() % 32'd248;
    b = 32'h8 + xs() % 32'd248;
    wr(8'h14, {16'h0, b[7:0], a[7:0]});
    wr(8'h44, 32'h12);
    pin(1, 1'b0);
    chk(32'(intDivValue[1]), a);
    pin(1, 1'b1);
    chk(32'(intDivValue[1]), b);
    wr(8'h18, 32'h0805);
    settle();
    chk(32'(intDivValue[2]), 32'h8);
    wr(8'h48, 32'h5);
    for (int v = 1; v >= 0; v--) begin
      pin(2, v[0]);
      chk(32'(busAddress), 32'h6A | v);
    end
    wr(8'h4C, 32'h6);
    wr(8'h50, 32'h16);
    for (int s = 0; s < 3; s++) begin
      pin(3, s[0]);
      pin(4, s[1]);
      chk(32'(inputSourceSelect), s);
    end
    $display("test select done");
    wr(`REG_OE, 32'h2A);
    repeat (30) @(posedge clk);
    #1 chk(32'(driverEnable), 32'h2A);
    wr(`REG_OE, 32'h3F);
    wr(8'h54, 32'h3F04);
    repeat (30) @(posedge clk);
    @(posedge clk);
    hwPins[5] <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk(32'(driverEnable), 32'h3F);
    repeat (24) @(posedge clk);
    #1 chk(32'(driverEnable), 32'h0);
    @(posedge clk);
    hwPins[5] <= 1'b0;
    repeat (12) @(posedge clk);
    #1 chk(32'(driverEnable), 32'h3F);
    chk(32'(diffOutTrue ^ diffOutComplement), 32'h3F);
    wr(`REG_OE, 32'h0);
    repeat (30) @(posedge clk);
    #1 chk(32'(driverEnable), 32'h3F);
    $display("test enable done");
    wr(8'h58, 32'h7);
    wr(8'h5C, 32'h7);
    a = xs();
    @(posedge clk);
    hwPins[7:6] <= a[1:0];
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1 chk(32'(driverEnable), 32'h0);
    chk(32'(profileSelect), {24'h0, a[1:0], 6'h0});
    @(posedge clk);
    hwPins[7:6] <= ~a[1:0];
    repeat (3) @(posedge clk);
    #1 chk(32'(profileSelect), {24'h0, a[1:0], 6'h0});
    rdc(`REG_CTRL, 32'h0);
    $display("test restart done");
    complete_run();
  end
endmodule : tb
bind clock_gen_pin_control clock_gen_pin_control_asserts #(.NUM_PINS(NUM_PINS),
  .NUM_OUT(NUM_OUT), .NUM_INT(NUM_INT),
  .NUM_MS(NUM_MS)) u_chk (.clk(clk), .rst(rst), .regReq(regReq), .regRdata(regRdata),
  .outClkLevel(outClkLevel), .diffOutTrue(diffOutTrue), .diffOutComplement(diffOutComplement),
  .driverEnable(driverEnable), .spreadCfg(spreadCfg), .intDivValue(intDivValue),
  .busAddress(busAddress), .profileSelect(profileSelect));
`default_nettype wire
